// File: eiw_defines.svh
// Constants for the external interrupt wake configuration block
`ifndef EIW_DEFINES_SVH
`define EIW_DEFINES_SVH

// Register byte addresses
`define EIW_ADDR_CFG0      32'h0000_0a20
`define EIW_ADDR_CFG1      32'h0000_0a24
`define EIW_ADDR_CFG2      32'h0000_0a28
`define EIW_ADDR_CLR       32'h0000_0a30

// Register word indices in the store
`define EIW_IDX_CFG0       2'h0
`define EIW_IDX_CFG1       2'h1
`define EIW_IDX_CFG2       2'h2
`define EIW_IDX_CLR        2'h3

// Reset values
`define EIW_RST_CFG        16'h0000
`define EIW_RST_CLR        16'hc000
`define EIW_RDATA_NONE     16'h0000

// Geometry
`define EIW_DATA_W         16
`define EIW_NUM_WORDS      4
`define EIW_NUM_LINES      12
`define EIW_LINES_PER_WORD 4
`define EIW_SLOT_W         4
`define EIW_EN_BIT         3
`define EIW_MODE_LSB       0
`define EIW_MODE_W         3

// Trigger mode codes
`define EIW_MODE_RISE      3'h0
`define EIW_MODE_FALL      3'h1
`define EIW_MODE_BOTH      3'h2
`define EIW_MODE_HIGH      3'h3
`define EIW_MODE_LOW       3'h4
`define EIW_MODE_FALL_ALT  3'h5
`define EIW_MODE_BOTH_ALT  3'h6
`define EIW_MODE_HIGH_ALT  3'h7

`endif

// File: eiw_pin_model.sv
// External pin sources
`timescale 1ns/10ps
module eiw_pin_model (
  // Clock
  input  wire logic        clk,
  // Wanted and driven levels
  input  wire logic [11:0] want,
  output logic      [11:0] pins
);
  initial pins = 12'h000;
  always @(negedge clk) pins <= want;
endmodule : eiw_pin_model

// File: eiw_pkg.sv
// Types and helper functions of the external interrupt wake block
`include "eiw_defines.svh"

package eiw_pkg;

  typedef enum logic [4:0] {
    EIW_TRIG_RISE = 5'b00001,
    EIW_TRIG_FALL = 5'b00010,
    EIW_TRIG_BOTH = 5'b00100,
    EIW_TRIG_HIGH = 5'b01000,
    EIW_TRIG_LOW  = 5'b10000
  } eiw_trig_t;

  typedef logic [`EIW_NUM_WORDS-1:0][`EIW_DATA_W-1:0] eiw_words_t;

  typedef struct packed {
    eiw_words_t              word;
    logic [`EIW_DATA_W-1:0]  rdata;
    logic                    rvalid;
  } eiw_rf_state_t;

  typedef struct packed {
    logic [`EIW_NUM_LINES-1:0] meta;
    logic [`EIW_NUM_LINES-1:0] sync;
    logic [`EIW_NUM_LINES-1:0] prev;
    logic [`EIW_NUM_LINES-1:0] irq;
    logic                      irq_any;
    logic                      wake;
  } eiw_top_state_t;

  // Mode code to trigger kind
  function automatic eiw_trig_t eiw_decode_trig(
    input logic [`EIW_MODE_W-1:0] code
  );
    eiw_trig_t t;
    t = EIW_TRIG_RISE;
    case (code)
      `EIW_MODE_RISE:     t = EIW_TRIG_RISE;
      `EIW_MODE_FALL,
      `EIW_MODE_FALL_ALT: t = EIW_TRIG_FALL;
      `EIW_MODE_BOTH,
      `EIW_MODE_BOTH_ALT: t = EIW_TRIG_BOTH;
      `EIW_MODE_HIGH,
      `EIW_MODE_HIGH_ALT: t = EIW_TRIG_HIGH;
      `EIW_MODE_LOW:      t = EIW_TRIG_LOW;
      default:            t = EIW_TRIG_RISE;
    endcase
    return t;
  endfunction : eiw_decode_trig

  // Trigger test on current and previous sample
  function automatic logic eiw_fires(
    input eiw_trig_t t,
    input logic      cur,
    input logic      prv
  );
    logic f;
    f = 1'b0;
    unique case (t)
      EIW_TRIG_RISE: f = cur & ~prv;
      EIW_TRIG_FALL: f = ~cur & prv;
      EIW_TRIG_BOTH: f = cur ^ prv;
      EIW_TRIG_HIGH: f = cur;
      EIW_TRIG_LOW:  f = ~cur;
    endcase
    return f;
  endfunction : eiw_fires

endpackage : eiw_pkg

// File: eiw_reg_if.sv
// Carrier between the register decode and the register store
`timescale 1ns/10ps
`include "eiw_defines.svh"

interface eiw_reg_if;
  import eiw_pkg::*;

  logic                   wr;
  logic                   rd;
  logic                   hit;
  logic [1:0]             idx;
  logic [`EIW_DATA_W-1:0] wdata;
  logic [`EIW_DATA_W-1:0] rdata;
  logic                   rvalid;
  eiw_words_t             words;

  modport store (
    input  wr,
    input  rd,
    input  hit,
    input  idx,
    input  wdata,
    output rdata,
    output rvalid,
    output words
  );

  modport user (
    output wr,
    output rd,
    output hit,
    output idx,
    output wdata,
    input  rdata,
    input  rvalid,
    input  words
  );
endinterface : eiw_reg_if

// File: eiw_regfile.sv
// Register store with registered read data
`timescale 1ns/10ps
`include "eiw_defines.svh"

module eiw_regfile
  import eiw_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Register access
  eiw_reg_if.store  rf
);

  eiw_rf_state_t s_q;
  eiw_rf_state_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.rvalid = rf.rd;
    if (rf.wr && rf.hit) begin
      s_d.word[rf.idx] = rf.wdata; // R8 R9
    end
    if (rf.rd) begin
      s_d.rdata = rf.hit ? s_q.word[rf.idx] : `EIW_RDATA_NONE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.word[`EIW_IDX_CFG0] <= `EIW_RST_CFG; // R7
      s_q.word[`EIW_IDX_CFG1] <= `EIW_RST_CFG;
      s_q.word[`EIW_IDX_CFG2] <= `EIW_RST_CFG;
      s_q.word[`EIW_IDX_CLR]  <= `EIW_RST_CLR; // R9
      s_q.rdata               <= `EIW_RDATA_NONE;
      s_q.rvalid              <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rf.rdata  = s_q.rdata;
  assign rf.rvalid = s_q.rvalid;
  assign rf.words  = s_q.word;

endmodule : eiw_regfile

// File: eiw_top.sv
// External interrupt line configuration, detection and wake logic
//
// How it works
// R1: line 3: enable bit 15, mode 14:12
// R2: line 2: enable bit 11, mode 10:8
// R3: line 1: enable bit 7, mode 6:4
// R4: line 0: enable bit 3, mode 2:0
// R5: modes rise, fall, both, high, low
// R6: codes 101,110,111 alias 001,010,011
// R7: disabled line silent; config resets to zero
// R8: config registers at 0xa20, 0xa24, 0xa28
// R9: clear register at 0xa30, resets 0xc000
// R10: second register serves lines 4 to 7
// R11: pins synchronised; edge by sample compare
// R12: level mode holds request while level present
`timescale 1ns/10ps
`include "eiw_defines.svh"

module eiw_top
  import eiw_pkg::*;
(
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RST,
  // Register port
  input  wire logic [31:0]               REG_ADDR,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  input  wire logic [`EIW_DATA_W-1:0]    REG_WDATA,
  output logic      [`EIW_DATA_W-1:0]    REG_RDATA,
  output logic                           REG_RVALID,
  // Power state
  input  wire logic                      HIBERNATE,
  // Wake pins
  input  wire logic [`EIW_NUM_LINES-1:0] WAKE_PIN,
  // Requests
  output logic      [`EIW_NUM_LINES-1:0] IRQ_REQ,
  output logic                           IRQ_ANY,
  output logic                           WAKE_REQ,
  // Observed state
  output logic      [`EIW_NUM_LINES-1:0] PIN_LEVEL,
  output logic      [`EIW_NUM_LINES-1:0] LINE_ENABLE,
  output logic      [`EIW_DATA_W-1:0]    CLEAR_WORD
);

  eiw_top_state_t s_q;
  eiw_top_state_t s_d;

  eiw_reg_if rif ();

  // Address decode to store index
  function automatic logic [2:0] decode_addr(input logic [31:0] a);
    logic [2:0] r;
    r = 3'h0;
    case (a)
      `EIW_ADDR_CFG0: r = {1'b1, `EIW_IDX_CFG0}; // R8
      `EIW_ADDR_CFG1: r = {1'b1, `EIW_IDX_CFG1}; // R8
      `EIW_ADDR_CFG2: r = {1'b1, `EIW_IDX_CFG2}; // R8
      `EIW_ADDR_CLR:  r = {1'b1, `EIW_IDX_CLR};  // R9
      default:        r = 3'h0;
    endcase
    return r;
  endfunction : decode_addr

  // Enable bit of one line
  function automatic logic line_en(
    input eiw_words_t w,
    input int         k
  );
    int wi;
    int bi;
    wi = k / `EIW_LINES_PER_WORD;
    bi = (k % `EIW_LINES_PER_WORD) * `EIW_SLOT_W + `EIW_EN_BIT;
    return w[wi][bi]; // R1 R2 R3 R4 R10
  endfunction : line_en

  // Mode field of one line
  function automatic logic [`EIW_MODE_W-1:0] line_mode(
    input eiw_words_t w,
    input int         k
  );
    int wi;
    int bi;
    wi = k / `EIW_LINES_PER_WORD;
    bi = (k % `EIW_LINES_PER_WORD) * `EIW_SLOT_W + `EIW_MODE_LSB;
    return w[wi][bi +: `EIW_MODE_W]; // R1 R2 R3 R4 R10
  endfunction : line_mode

  logic [2:0] dec;

  assign dec       = decode_addr(REG_ADDR);
  assign rif.wr    = REG_WR;
  assign rif.rd    = REG_RD;
  assign rif.hit   = dec[2];
  assign rif.idx   = dec[1:0];
  assign rif.wdata = REG_WDATA;

  eiw_regfile u_regfile (
    .clk (CLK),
    .rst (RST),
    .rf  (rif.store)
  );

  // Per line enable and trigger kind
  logic      [`EIW_NUM_LINES-1:0] en;
  eiw_trig_t                      trig [`EIW_NUM_LINES];

  always_comb begin
    for (int k = 0; k < `EIW_NUM_LINES; k++) begin
      en[k]   = line_en(rif.words, k);
      trig[k] = eiw_decode_trig(line_mode(rif.words, k)); // R5 R6
    end
  end

  // Detection and wake
  always_comb begin
    s_d      = s_q;
    s_d.meta = WAKE_PIN;  // R11
    s_d.sync = s_q.meta;  // R11
    s_d.prev = s_q.sync;  // R11
    for (int k = 0; k < `EIW_NUM_LINES; k++) begin
      // Level modes follow the pin, edges pulse once
      s_d.irq[k] = en[k] &
                   eiw_fires(trig[k], s_q.sync[k], s_q.prev[k]); // R7 R12
    end
    s_d.irq_any = |s_d.irq;
    s_d.wake    = HIBERNATE & (|s_d.irq); // R1 R2 R3 R4
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q.meta    <= '0;
      s_q.sync    <= '0;
      s_q.prev    <= '0;
      s_q.irq     <= '0;
      s_q.irq_any <= 1'b0;
      s_q.wake    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA   = rif.rdata;
  assign REG_RVALID  = rif.rvalid;
  assign IRQ_REQ     = s_q.irq;
  assign IRQ_ANY     = s_q.irq_any;
  assign WAKE_REQ    = s_q.wake;
  assign PIN_LEVEL   = s_q.sync;
  assign LINE_ENABLE = en;
  assign CLEAR_WORD  = rif.words[`EIW_IDX_CLR];

endmodule : eiw_top

// File: eiw_top_asserts.sv
// Checker on the ports of the wake block
`timescale 1ns/10ps
module eiw_top_asserts (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Register port
  input wire logic [31:0] REG_ADDR,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_RVALID,
  // Pins and requests
  input wire logic        HIBERNATE,
  input wire logic [11:0] WAKE_PIN,
  input wire logic [11:0] IRQ_REQ,
  input wire logic        IRQ_ANY,
  input wire logic        WAKE_REQ,
  input wire logic [11:0] PIN_LEVEL,
  input wire logic [11:0] LINE_ENABLE,
  input wire logic [15:0] CLEAR_WORD
);
  wire logic [3:0] en_w = {REG_WDATA[15], REG_WDATA[11], REG_WDATA[7],
                           REG_WDATA[3]};
  wire logic mapped = REG_ADDR inside {32'h0000_0a20, 32'h0000_0a24,
                                       32'h0000_0a28, 32'h0000_0a30};
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  rd_latency_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered");
  rvalid_only_a: assert property (!REG_RD |=> !REG_RVALID)
    else $error("spurious read valid");
  unmapped_rd_a: assert property (REG_RD && !mapped |=> REG_RDATA == 16'h0)
    else $error("unmapped read not zero");
  cfg0_write_a: assert property (REG_WR && REG_ADDR == 32'h0000_0a20
    |=> LINE_ENABLE[3:0] == $past(en_w)) else $error("line 0-3 enable");
  cfg1_write_a: assert property (REG_WR && REG_ADDR == 32'h0000_0a24
    |=> LINE_ENABLE[7:4] == $past(en_w)) else $error("line 4-7 enable");
  clr_write_a: assert property (REG_WR && REG_ADDR == 32'h0000_0a30
    |=> CLEAR_WORD == $past(REG_WDATA)) else $error("clear word");
  disabled_quiet_a: assert property ((IRQ_REQ & ~$past(LINE_ENABLE)) == 0)
    else $error("disabled line requests");
  sync_delay_a: assert property (!$past(RST, 2) |->
    PIN_LEVEL == $past(WAKE_PIN, 2)) else $error("pin sync delay");
  wake_gate_a: assert property (WAKE_REQ == ($past(HIBERNATE) && IRQ_ANY))
    else $error("wake request");
  cover property (REG_RD ##1 REG_RVALID);
  cover property (WAKE_REQ);
  cover property ($rose(IRQ_ANY));
endmodule : eiw_top_asserts

// File: eiw_top_tb_top.sv
// Self-checking bench of the wake block
`timescale 1ns/10ps
module eiw_top_tb_top;
  logic        CLK, RST, REG_WR, REG_RD, REG_RVALID, HIBERNATE;
  logic        IRQ_ANY, WAKE_REQ, ew;
  logic [31:0] REG_ADDR, seed;
  logic [15:0] REG_WDATA, REG_RDATA, CLEAR_WORD, w;
  logic [11:0] WAKE_PIN, IRQ_REQ, PIN_LEVEL, LINE_ENABLE, want;
  logic [11:0] m1, m2, mp, ei, f;
  logic [3:0]  s;
  logic [15:0] mdl [4];
  logic [31:0] ra [5] = '{32'h0000_0a20, 32'h0000_0a24, 32'h0000_0a28,
                         32'h0000_0a30, 32'h0000_0a2c};
  int          bad_count, compares;

  eiw_pin_model i_eiw_pin_model (.clk(CLK), .want(want), .pins(WAKE_PIN));
  eiw_top i_eiw_top (
    .CLK         (CLK),
    .RST         (RST),
    .REG_ADDR    (REG_ADDR),
    .REG_WR      (REG_WR),
    .REG_RD      (REG_RD),
    .REG_WDATA   (REG_WDATA),
    .REG_RDATA   (REG_RDATA),
    .REG_RVALID  (REG_RVALID),
    .HIBERNATE   (HIBERNATE),
    .WAKE_PIN    (WAKE_PIN),
    .IRQ_REQ     (IRQ_REQ),
    .IRQ_ANY     (IRQ_ANY),
    .WAKE_REQ    (WAKE_REQ),
    .PIN_LEVEL   (PIN_LEVEL),
    .LINE_ENABLE (LINE_ENABLE),
    .CLEAR_WORD  (CLEAR_WORD)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic bit fire(input int m, input bit c, input bit p);
    case (m)
      0: return c & !p;
      1, 5: return !c & p;
      2, 6: return c ^ p;
      3, 7: return c;
      default: return !c;
    endcase
  endfunction : fire

  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr_reg(input int i, input logic [15:0] d);
    REG_ADDR = ra[i];
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK);
    if (i < 4) mdl[i] = d;
  endtask : wr_reg

  task automatic rd_reg(input int i);
    logic [11:0] e;
    REG_ADDR = ra[i];
    REG_WR = 1'b0;
    REG_RD = 1'b1;
    @(negedge CLK);
    for (int k = 0; k < 12; k++) e[k] = mdl[k/4][4*(k%4)+3];
    chk("read", i < 4 ? mdl[i] : 16'h0000, REG_RDATA);
    chk("rvalid", 16'h0001, {15'h0, REG_RVALID});
    chk("enable", {4'h0, e}, {4'h0, LINE_ENABLE});
    chk("clear", mdl[3], CLEAR_WORD);
  endtask : rd_reg

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      {m1, m2, mp, ei, ew} <= '0;
    end else begin
      for (int k = 0; k < 12; k++) begin
        s = mdl[k/4][4*(k%4)+:4];
        f[k] = s[3] & fire(s[2:0], m2[k], mp[k]);
      end
      m1 <= WAKE_PIN;
      m2 <= m1;
      mp <= m2;
      ei <= f;
      ew <= HIBERNATE & |f;
    end
  end

  always @(negedge CLK) begin
    if (!RST) begin
      chk("req", {2'h0, ew, |ei, ei},
          {2'h0, WAKE_REQ, IRQ_ANY, IRQ_REQ});
      chk("level", {4'h0, m2}, {4'h0, PIN_LEVEL});
    end
  end

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    mdl = '{16'h0000, 16'h0000, 16'h0000, 16'hc000};
    RST = 1'b1;
    {REG_ADDR, REG_WDATA, want, seed} = {60'h0, 32'hf69157e3};
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    HIBERNATE = 1'b0;
    repeat (5) @(negedge CLK);
    RST = 1'b0;
    for (int i = 0; i < 5; i++) rd_reg(i);
    for (int r = 0; r < 8; r++) begin
      for (int j = 0; j < 5; j++) begin
        seed = lfsr(seed);
        for (int k = 0; k < 4; k++) w[4*k+:4] = {seed[k] | r < 6, 3'(r + k)};
        REG_RD = 1'b0;
        wr_reg(j, j < 3 ? w : seed[15:0]);
      end
      for (int i = 0; i < 5; i++) rd_reg(i);
      REG_RD = 1'b0;
      repeat (40) begin
        seed = lfsr(seed);
        if (seed[13]) want = seed[11:0];
        HIBERNATE = seed[12];
        @(negedge CLK);
      end
    end
    report_and_stop();
  end
endmodule : eiw_top_tb_top

bind eiw_top eiw_top_asserts i_eiw_top_asserts (.*);
